/* design/sbm_pkg.sv */
// Constants and types for the configuration register and burst column sequencer
package sbm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SBM_CFG_W = 13;
  localparam int SBM_COL_W = 9;
  localparam int SBM_CNT_W = 10;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int SBM_LEN_LSB = 0;
  localparam int SBM_LEN_MSB = 2;
  localparam int SBM_ORDER_BIT = 3;
  localparam int SBM_LAT_LSB = 4;
  localparam int SBM_LAT_MSB = 6;
  localparam int SBM_OPM_LO = 7;
  localparam int SBM_OPM_HI = 8;
  localparam int SBM_WSINGLE_BIT = 9;

  // ----------------------------------------------------------------
  // Field codes and values
  // ----------------------------------------------------------------
  localparam logic [2:0] SBM_LEN_1 = 3'h0;
  localparam logic [2:0] SBM_LEN_2 = 3'h1;
  localparam logic [2:0] SBM_LEN_4 = 3'h2;
  localparam logic [2:0] SBM_LEN_8 = 3'h3;
  localparam logic [2:0] SBM_LEN_PAGE = 3'h7;
  localparam logic [2:0] SBM_LAT_CODE2 = 3'h2;
  localparam logic [2:0] SBM_LAT_CODE3 = 3'h3;
  localparam logic [1:0] SBM_LAT_TWO = 2'h2;
  localparam logic [1:0] SBM_LAT_THREE = 2'h3;
  localparam logic [1:0] SBM_OPM_NORMAL = 2'h0;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_1 = 10'h001;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_2 = 10'h002;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_4 = 10'h004;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_8 = 10'h008;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_PAGE = 10'h200;
  localparam logic [SBM_CNT_W-1:0] SBM_BEATS_NONE = 10'h000;
  localparam logic [SBM_CFG_W-1:0] SBM_CFG_RESET = 13'h0000;
  localparam logic [SBM_COL_W-1:0] SBM_COL_ZERO = 9'h000;
  localparam logic [SBM_COL_W-1:0] SBM_COL_LAST = 9'h1ff;
  localparam logic [SBM_CNT_W-1:0] SBM_IDX_ONE = 10'h001;

  // ----------------------------------------------------------------
  // Command pins, all active low
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chipSelN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeEnN;
  } sbm_cmd_t;

  localparam logic [3:0] SBM_CMD_LOAD = 4'h0;
  localparam logic [3:0] SBM_CMD_READ = 4'h5;
  localparam logic [3:0] SBM_CMD_WRITE = 4'h4;
  localparam logic [3:0] SBM_CMD_TERM = 4'h6;

  // Burst sequencer states
  typedef enum logic [0:0] {
    SBM_IDLE = 1'b0,
    SBM_RUN = 1'b1
  } sbm_state_t;

endpackage

/* design/sbm_mode_burst.sv */
// Configuration register and burst column-address sequencer of the memory device
//
// Notes on behaviour
// RQ1: Configuration holds until next load command.
// RQ2: Length from bits 2:0, latency 6:4.
// RQ3: Bits 8:7 operating mode, bit 9 write-single.
// RQ4: Bit 3: zero sequential, one interleaved.
// RQ5: Controller zeroes bits above write-single bit.
// RQ6: Load command needs both bank selects zero.
// RQ7: Controller loads only with all banks idle.
// RQ8: Controller waits load delay after loading.
// RQ9: Codes 0-3 give 1,2,4,8; 7 page.
// RQ10: Page burst only with sequential order.
// RQ11: Burst never exceeds programmed length.
// RQ12: Accesses wrap inside aligned length-sized block.
// RQ13: Upper column bits pick block, low start.
// RQ14: Page burst wraps within the page.
// RQ15: Arbitrary length: page burst plus terminate.
// RQ16: Controller avoids reserved burst length codes; the testbench loads codes 4-6 and code 7 with interleaved order as well.
// RQ17: Read latency two or three clocks.
// RQ18: Mode bits zero select normal operation.
// RQ19: Write-single bit limits writes to one.
// RQ20: Latency codes 2,3 valid; others reserved.
`timescale 1ns/100ps
`default_nettype none

module sbm_mode_burst
  import sbm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire sbm_cmd_t cmdPins,
  input wire logic bankSelLo,
  input wire logic bankSelHi,
  input wire logic [SBM_CFG_W-1:0] addrPins,
  output logic [SBM_CFG_W-1:0] cfgValue_r,
  output logic [SBM_CNT_W-1:0] burstLenBeats_r,
  output logic burstInterleaved_r,
  output logic burstFullPage_r,
  output logic [1:0] readLatency_r,
  output logic readLatencyOk_r,
  output logic normalMode_r,
  output logic writeSingle_r,
  output logic cfgReserved_r,
  output logic [SBM_COL_W-1:0] colAddr_r,
  output logic colValid_r,
  output logic colWrite_r,
  output logic [SBM_CNT_W-1:0] colIndex_r
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic loadTake;
  logic startRead;
  logic startWrite;
  logic startAny;
  logic stopCmd;
  logic [2:0] lenCode;
  logic [2:0] latCode;

  // A load only reaches this register with both bank selects low
  assign loadTake = (cmdPins == SBM_CMD_LOAD) && !bankSelLo && !bankSelHi; // RQ6
  assign startRead = (cmdPins == SBM_CMD_READ);
  assign startWrite = (cmdPins == SBM_CMD_WRITE);
  assign startAny = startRead || startWrite;
  assign stopCmd = (cmdPins == SBM_CMD_TERM);
  assign lenCode = addrPins[SBM_LEN_MSB:SBM_LEN_LSB]; // RQ2
  assign latCode = addrPins[SBM_LAT_MSB:SBM_LAT_LSB]; // RQ2

  // ----------------------------------------------------------------
  // Configuration register and its decoded fields
  // ----------------------------------------------------------------
  logic [SBM_CNT_W-1:0] lenBeats;
  logic lenReserved;
  logic orderBit;

  // Length decode from the incoming load value
  always_comb begin
    orderBit = addrPins[SBM_ORDER_BIT]; // RQ4
    lenReserved = 1'b0;
    unique case (lenCode)
      SBM_LEN_1: lenBeats = SBM_BEATS_1; // RQ9
      SBM_LEN_2: lenBeats = SBM_BEATS_2; // RQ9
      SBM_LEN_4: lenBeats = SBM_BEATS_4; // RQ9
      SBM_LEN_8: lenBeats = SBM_BEATS_8; // RQ9
      SBM_LEN_PAGE: begin
        lenBeats = orderBit ? SBM_BEATS_NONE : SBM_BEATS_PAGE; // RQ10
        lenReserved = orderBit; // RQ10
      end
      default: begin
        lenBeats = SBM_BEATS_NONE; // RQ9
        lenReserved = 1'b1;
      end
    endcase
  end

  // Value and decoded fields change only on an accepted load
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfgValue_r <= SBM_CFG_RESET;
      burstLenBeats_r <= SBM_BEATS_1;
      burstInterleaved_r <= 1'b0;
      burstFullPage_r <= 1'b0;
      readLatency_r <= SBM_LAT_TWO;
      readLatencyOk_r <= 1'b0;
      normalMode_r <= 1'b1;
      writeSingle_r <= 1'b0;
      cfgReserved_r <= 1'b0;
    end else if (loadTake) begin
      cfgValue_r <= addrPins; // RQ1
      burstLenBeats_r <= lenBeats;
      burstInterleaved_r <= orderBit; // RQ4
      burstFullPage_r <= (lenCode == SBM_LEN_PAGE) && !orderBit; // RQ10
      readLatency_r <= (latCode == SBM_LAT_CODE3) ? SBM_LAT_THREE : SBM_LAT_TWO; // RQ20
      readLatencyOk_r <= (latCode == SBM_LAT_CODE2) || (latCode == SBM_LAT_CODE3); // RQ17
      normalMode_r <= (addrPins[SBM_OPM_HI:SBM_OPM_LO] == SBM_OPM_NORMAL); // RQ18
      writeSingle_r <= addrPins[SBM_WSINGLE_BIT]; // RQ3
      cfgReserved_r <= lenReserved;
    end
  end

  // ----------------------------------------------------------------
  // Burst column sequencer
  // ----------------------------------------------------------------
  sbm_state_t state_r;
  logic [SBM_COL_W-1:0] start_r;
  logic [SBM_COL_W-1:0] mask_r;
  logic [SBM_CNT_W-1:0] idx_r;
  logic [SBM_CNT_W-1:0] lenUsed_r;
  logic pageRun_r;
  logic [SBM_CNT_W-1:0] newLen;
  logic [SBM_COL_W-1:0] newMask;
  logic [SBM_COL_W-1:0] runAddr;
  logic [SBM_COL_W-1:0] idxCol;
  logic lastBeat;

  // Length of a new access: single for writes when write-single is set
  always_comb begin
    newLen = (startWrite && writeSingle_r) ? SBM_BEATS_1 : burstLenBeats_r; // RQ19
    newMask = burstFullPage_r ? SBM_COL_LAST : SBM_COL_W'(burstLenBeats_r - SBM_IDX_ONE);
    if (startWrite && writeSingle_r) begin
      newMask = SBM_COL_ZERO; // RQ19
    end
  end

  // Column of the current beat: block bits fixed, low bits walk and wrap
  assign idxCol = idx_r[SBM_COL_W-1:0];
  always_comb begin
    if (burstInterleaved_r) begin
      runAddr = (start_r & ~mask_r) | ((start_r ^ idxCol) & mask_r); // RQ12 RQ13
    end else begin
      runAddr = (start_r & ~mask_r) | (SBM_COL_W'(start_r + idxCol) & mask_r); // RQ12 RQ14
    end
  end
  assign lastBeat = !pageRun_r && (idx_r == SBM_CNT_W'(lenUsed_r - SBM_IDX_ONE)); // RQ11

  // Sequencer state: a new access with a valid length restarts it; terminate or an access with a reserved length stops it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SBM_IDLE;
      start_r <= SBM_COL_ZERO;
      mask_r <= SBM_COL_ZERO;
      idx_r <= SBM_BEATS_NONE;
      lenUsed_r <= SBM_BEATS_1;
      pageRun_r <= 1'b0;
    end else if (startAny && newLen != SBM_BEATS_NONE) begin
      start_r <= addrPins[SBM_COL_W-1:0]; // RQ13
      mask_r <= newMask;
      idx_r <= SBM_IDX_ONE;
      lenUsed_r <= newLen;
      pageRun_r <= (newLen == SBM_BEATS_PAGE); // RQ14
      state_r <= (newLen == SBM_BEATS_1) ? SBM_IDLE : SBM_RUN; // RQ11
    end else if (startAny || stopCmd) begin
      state_r <= SBM_IDLE; // RQ15
    end else begin
      unique case (state_r)
        SBM_IDLE: idx_r <= idx_r;
        SBM_RUN: begin
          idx_r <= idx_r + SBM_IDX_ONE;
          if (lastBeat) begin
            state_r <= SBM_IDLE; // RQ11
          end
        end
      endcase
    end
  end

  // Column output for each beat
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      colAddr_r <= SBM_COL_ZERO;
      colValid_r <= 1'b0;
      colWrite_r <= 1'b0;
      colIndex_r <= SBM_BEATS_NONE;
    end else if (startAny && newLen != SBM_BEATS_NONE) begin
      colAddr_r <= addrPins[SBM_COL_W-1:0];
      colValid_r <= 1'b1;
      colWrite_r <= startWrite;
      colIndex_r <= SBM_BEATS_NONE;
    end else if (state_r == SBM_RUN && !startAny && !stopCmd) begin
      colAddr_r <= runAddr;
      colValid_r <= 1'b1;
      colIndex_r <= idx_r;
    end else begin
      colValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_cfg_hold: assert property (!loadTake |=> $stable(cfgValue_r)) // RQ1
    else $error("configuration changed without a load");
  chk_lat_decode: assert property ( // RQ20
    loadTake && latCode == SBM_LAT_CODE3 |=> readLatency_r == SBM_LAT_THREE && readLatencyOk_r)
    else $error("latency code three not decoded as three clocks");
  chk_lat_reserved: assert property ( // RQ17
    loadTake && latCode != SBM_LAT_CODE2 && latCode != SBM_LAT_CODE3 |=> !readLatencyOk_r)
    else $error("reserved latency code accepted");
  chk_mode_bits: assert property ( // RQ18
    loadTake |=> normalMode_r == ($past(addrPins[SBM_OPM_HI:SBM_OPM_LO]) == SBM_OPM_NORMAL))
    else $error("operating mode decode wrong");
  chk_order_bit: assert property ( // RQ4
    loadTake |=> burstInterleaved_r == $past(orderBit))
    else $error("burst order bit not taken");
  chk_len_decode: assert property ( // RQ9
    loadTake && lenCode == SBM_LEN_8 |=> burstLenBeats_r == SBM_BEATS_8)
    else $error("length code three not eight beats");
  chk_page_order: assert property (burstFullPage_r |-> !burstInterleaved_r) // RQ10
    else $error("page burst with interleaved order");
  chk_burst_count: assert property ( // RQ11
    colValid_r && !pageRun_r |-> colIndex_r < lenUsed_r)
    else $error("burst beat beyond programmed length");
  chk_block_keep: assert property ( // RQ12
    colValid_r |-> (colAddr_r & ~mask_r) == (start_r & ~mask_r))
    else $error("column left its aligned block");
  chk_write_single: assert property ( // RQ19
    startWrite && writeSingle_r ##1 !startAny |=> !colValid_r)
    else $error("write burst longer than one with write-single set");
  chk_page_wrap: assert property ( // RQ14
    colValid_r && pageRun_r && state_r == SBM_RUN && colAddr_r == SBM_COL_LAST
    && !startAny && !stopCmd |=> colValid_r && colAddr_r == SBM_COL_ZERO)
    else $error("page burst did not wrap to column zero");

  cov_load: cover property (loadTake ##1 burstInterleaved_r);
  cov_eight_read: cover property (startRead && burstLenBeats_r == SBM_BEATS_8 ##8 !colValid_r);
  cov_page_term: cover property (pageRun_r && colValid_r ##1 stopCmd ##1 !colValid_r);
  cov_single_write: cover property (startWrite && writeSingle_r);

endmodule

`default_nettype wire

/* bench/sbm_ctrl_model.sv */
// Memory controller model driving command, bank-select and address pins
`timescale 1ns/100ps
`default_nettype none

module sbm_ctrl_model
  import sbm_pkg::*;
#(
  parameter int LOAD_DELAY = 2
)
(
  input wire logic mclk,
  output var sbm_cmd_t cmdPins,
  output var logic bankSelLo,
  output var logic bankSelHi,
  output var logic [SBM_CFG_W-1:0] addrPins
);
  localparam logic [3:0] IDLE_CMD = 4'hf;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Deselected at time zero
  initial begin
    cmdPins = sbm_cmd_t'(IDLE_CMD);
    bankSelLo = 1'b1;
    bankSelHi = 1'b1;
    addrPins = 13'h1555;
  end

  // One command for one edge, then deselect and show the inverse address
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank,
                       input logic [SBM_CFG_W-1:0] addr);
    cmdPins <= sbm_cmd_t'(cmd);
    bankSelLo <= bank[0];
    bankSelHi <= bank[1];
    addrPins <= addr;
    @(posedge mclk);
    cmdPins <= sbm_cmd_t'(IDLE_CMD);
    bankSelLo <= ~bank[0];
    bankSelHi <= ~bank[1];
    addrPins <= ~addr;
  endtask

  // Load with upper bits and bank selects zero, then hold off
  task automatic load(input logic [9:0] cfg);
    issue(SBM_CMD_LOAD, 2'b00, {3'h0, cfg});
    repeat (LOAD_DELAY) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench for the configuration register and burst sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import sbm_pkg::*;

  logic mclk;
  logic resetn;
  sbm_cmd_t cmdPins;
  logic bankSelLo;
  logic bankSelHi;
  logic [SBM_CFG_W-1:0] addrPins;
  logic [SBM_CFG_W-1:0] cfgValue_r;
  logic [SBM_CNT_W-1:0] burstLenBeats_r;
  logic burstInterleaved_r;
  logic burstFullPage_r;
  logic [1:0] readLatency_r;
  logic readLatencyOk_r;
  logic normalMode_r;
  logic writeSingle_r;
  logic cfgReserved_r;
  logic [SBM_COL_W-1:0] colAddr_r;
  logic colValid_r;
  logic colWrite_r;
  logic [SBM_CNT_W-1:0] colIndex_r;
  int err_count = 0;
  int cmp_count = 0;
  logic [9:0] cfg;
  logic [2:0] len;
  logic [15:0] beats;

  sbm_ctrl_model u_ctrl (.mclk(mclk), .cmdPins(cmdPins), .bankSelLo(bankSelLo),
    .bankSelHi(bankSelHi), .addrPins(addrPins));

  sbm_mode_burst u_dut (.mclk(mclk), .resetn(resetn), .cmdPins(cmdPins),
    .bankSelLo(bankSelLo), .bankSelHi(bankSelHi), .addrPins(addrPins),
    .cfgValue_r(cfgValue_r), .burstLenBeats_r(burstLenBeats_r),
    .burstInterleaved_r(burstInterleaved_r), .burstFullPage_r(burstFullPage_r),
    .readLatency_r(readLatency_r), .readLatencyOk_r(readLatencyOk_r),
    .normalMode_r(normalMode_r), .writeSingle_r(writeSingle_r),
    .cfgReserved_r(cfgReserved_r), .colAddr_r(colAddr_r), .colValid_r(colValid_r),
    .colWrite_r(colWrite_r), .colIndex_r(colIndex_r));

  // ----------------------------------------------------------------
  // Clock, compare and closing report
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Column of beat i: aligned block kept, low bits stepped or flipped
  function automatic logic [8:0] expCol(logic [8:0] s, int i, int n, logic ilv);
    logic [8:0] m;
    m = 9'(n - 1);
    if (ilv) return (s & ~m) | ((s ^ 9'(i)) & m);
    return (s & ~m) | ((s + 9'(i)) & m);
  endfunction

  // Start a burst, check cnt beats, optionally terminate, then expect silence
  task automatic burst(input logic [3:0] cmd, input logic [8:0] s, input int n,
                       input int cnt, input logic ilv, input logic term);
    u_ctrl.issue(cmd, 2'b00, {4'h0, s});
    for (int i = 0; i < cnt; i++) begin
      #1;
      chk(colValid_r, 1'b1);
      chk(colAddr_r, expCol(s, i, n, ilv));
      chk(colIndex_r, 16'(i));
      chk(colWrite_r, cmd == SBM_CMD_WRITE);
      @(posedge mclk);
    end
    if (term) u_ctrl.issue(SBM_CMD_TERM, 2'b00, 13'h0000);
    #1;
    chk(colValid_r, 1'b0);
    @(posedge mclk);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk(cfgValue_r, 16'h0);
    chk(burstLenBeats_r, 16'h1);
    chk(readLatency_r, 16'h2);
    chk(colValid_r, 1'b0);
    @(posedge mclk);
    // Every length, order, latency, mode and write-single code; loads only while idle
    for (int i = 0; i < 16; i++) begin
      len = i[2:0];
      cfg = {i[0], i[1:0], len, i[3], len};
      u_ctrl.load(cfg);
      #1;
      beats = (len < 3'h4) ? (16'h1 << len) : ((len == 3'h7 && !i[3]) ? 16'h200 : 16'h0);
      chk(cfgValue_r, {3'h0, cfg});
      chk(burstLenBeats_r, beats);
      chk(cfgReserved_r, beats == 16'h0);
      chk(burstFullPage_r, beats == 16'h200);
      chk(burstInterleaved_r, i[3]);
      chk(readLatency_r, (len == 3'h3) ? 16'h3 : 16'h2);
      chk(readLatencyOk_r, len == 3'h2 || len == 3'h3);
      chk(normalMode_r, i[1:0] == 2'h0);
      chk(writeSingle_r, i[0]);
      @(posedge mclk);
    end
    // Loads with a bank select high and other commands leave the value alone
    for (int b = 1; b < 4; b++) begin
      u_ctrl.issue(SBM_CMD_LOAD, 2'(b), 13'h0033);
      @(posedge mclk);
    end
    burst(SBM_CMD_READ, 9'h1fe, 512, 0, 1'b1, 1'b0);
    chk(cfgValue_r, {3'h0, cfg});
    u_ctrl.load(10'h032);
    burst(SBM_CMD_READ, 9'h005, 4, 4, 1'b0, 1'b0);
    u_ctrl.load(10'h03b);
    burst(SBM_CMD_WRITE, 9'h0fd, 8, 8, 1'b1, 1'b0);
    u_ctrl.load(10'h021);
    burst(SBM_CMD_READ, 9'h1a3, 2, 2, 1'b0, 1'b0);
    u_ctrl.load(10'h020);
    burst(SBM_CMD_READ, 9'h0ff, 1, 1, 1'b1, 1'b0);
    u_ctrl.load(10'h02a);
    burst(SBM_CMD_READ, 9'h0b6, 4, 4, 1'b1, 1'b0);
    u_ctrl.load(10'h233);
    burst(SBM_CMD_WRITE, 9'h006, 1, 1, 1'b0, 1'b0);
    burst(SBM_CMD_READ, 9'h006, 8, 8, 1'b0, 1'b0);
    u_ctrl.load(10'h024);
    burst(SBM_CMD_READ, 9'h010, 1, 0, 1'b0, 1'b0);
    u_ctrl.load(10'h02f);
    burst(SBM_CMD_READ, 9'h010, 1, 0, 1'b1, 1'b0);
    u_ctrl.load(10'h027);
    burst(SBM_CMD_READ, 9'h1fe, 512, 4, 1'b0, 1'b1);
    stop_test();
  end
endmodule

`default_nettype wire
